// File: rtl/rfct_regs.vh
// Purpose: constants for the countdown timer register block
// Assumes: wishbone byte registers, index times four is the byte address
// Notes: header holds definitions only
`ifndef RFCT_REGS_VH
`define RFCT_REGS_VH
// register indices
`define RFCT_IDX_PREV_HI 8'h1c
`define RFCT_IDX_PREV_LO 8'h1d
`define RFCT_IDX_CTRL 8'h1e
`define RFCT_IDX_RLD_HI 8'h1f
`define RFCT_IDX_RLD_LO 8'h20
`define RFCT_IDX_CNT_HI 8'h21
`define RFCT_IDX_CNT_LO 8'h22
`define RFCT_IDX_IRQ_STAT 8'h30
`define RFCT_IDX_IRQ_MASK 8'h31
`define RFCT_IDX_RUN 8'h32
// control fields
`define RFCT_CTRL_STOPRX 7
`define RFCT_CTRL_START_HI 5
`define RFCT_CTRL_START_LO 4
`define RFCT_CTRL_AUTORST 3
`define RFCT_CTRL_CLK_HI 1
`define RFCT_CTRL_CLK_LO 0
`define RFCT_CTRL_WMASK 8'hbb
`define RFCT_CTRL_RST 8'h00
// start modes
`define RFCT_START_NONE 2'h0
`define RFCT_START_TXEND 2'h1
`define RFCT_START_LFO 2'h2
`define RFCT_START_LFO_UF 2'h3
// clock sources
`define RFCT_CLK_CARRIER 2'h0
`define RFCT_CLK_DIV 2'h1
`define RFCT_CLK_T0 2'h2
`define RFCT_CLK_T1 2'h3
// carrier / divided clock figures in kHz
`define RFCT_CARRIER_KHZ 13560
`define RFCT_DIVCLK_KHZ 212
`define RFCT_SYS_KHZ 200000
// status bits and reset values
`define RFCT_IRQ_UF 0
`define RFCT_IRQ_STOP 1
`define RFCT_IRQ_W 2
`define RFCT_BYTE_RST 8'h00
`define RFCT_CNT_RST 16'h0000
// bits of a received count before the stop
`define RFCT_RX_STOP_BITS 3'h4
`define RFCT_RX_CNT_W 3
`define RFCT_ADR_LSB 2
`endif

// File: rtl/rfct_timer.v
// Purpose: 16-bit countdown timer of a contactless reader front end
// Assumes: carrier and divided clock ticks are one-cycle enables on clk_i
// Notes: rx and tx event pins are asynchronous and get two sync flops plus an edge flop
//
// How it works
// - with stop_on_receive set, timer halts after the first 4 received bits.
// - in oscillator trimming modes stop_on_receive is ignored.
// - start mode 00 never auto starts; 01 starts on transmission end.
// - modes 10 and 11 trim the oscillator, edges start/stop, 11 underflows.
// - auto_restart set: reload on reaching zero and keep counting, except mode 10, which holds at zero.
// - auto_restart clear: count to zero, then stop until next start, except mode 10, which holds at zero and keeps running.
// - every underflow sets the underflow interrupt flag.
// - clock_select 00 uses carrier tick, 01 the divided tick.
// - clock_select 10 and 11 count underflows of timer zero or one.
// - each start loads the counter from the two reload bytes.
// - writing reload bytes while running leaves the count untouched.
// - live count reads as two read-only bytes, high and low.
// - previous timer count reads as read-only high and low bytes.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rfct_regs.vh"

module rfct_timer #(
  parameter CARRIER_KHZ = `RFCT_CARRIER_KHZ,
  parameter DIVCLK_KHZ = `RFCT_DIVCLK_KHZ,
  parameter SYS_KHZ = `RFCT_SYS_KHZ
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  input wire tx_end_i,
  input wire rx_bit_i,
  input wire rx_active_i,
  input wire lfo_i,
  input wire t0_underflow_i,
  input wire t1_underflow_i,
  input wire [15:0] prev_count_i,
  output reg underflow_o,
  output reg running_o,
  output wire irq_o
);

  // ---------------------------------------------------------------
  // tick generation
  // ---------------------------------------------------------------
  // phase accumulators; the carrier is not an integer divisor of clk_i
  localparam [17:0] CAR_STEP = CARRIER_KHZ;
  localparam [17:0] DIV_STEP = DIVCLK_KHZ;
  localparam [17:0] SYS_MOD = SYS_KHZ;
  reg [17:0] car_acc_r;
  reg [17:0] div_acc_r;
  wire [18:0] car_sum = {1'b0, car_acc_r} + {1'b0, CAR_STEP};
  wire [18:0] div_sum = {1'b0, div_acc_r} + {1'b0, DIV_STEP};
  wire car_tick = (car_sum >= {1'b0, SYS_MOD});
  wire div_tick = (div_sum >= {1'b0, SYS_MOD});

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      car_acc_r <= 18'h00000;
      div_acc_r <= 18'h00000;
    end else begin
      car_acc_r <= car_tick ? car_sum[17:0] - SYS_MOD : car_sum[17:0];
      div_acc_r <= div_tick ? div_sum[17:0] - SYS_MOD : div_sum[17:0];
    end
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  reg [2:0] sync1_r;
  reg [2:0] sync2_r;
  reg [2:0] sync3_r;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sync3_r <= 3'h0;
    end else begin
      sync1_r <= {lfo_i, rx_bit_i, tx_end_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  wire tx_end_rise = sync2_r[0] & ~sync3_r[0];
  wire rx_bit_rise = sync2_r[1] & ~sync3_r[1];
  wire lfo_rise = sync2_r[2] & ~sync3_r[2];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [7:0] ctrl_r;
  reg [7:0] rld_hi_r;
  reg [7:0] rld_lo_r;
  reg [`RFCT_IRQ_W-1:0] irq_stat_r;
  reg [`RFCT_IRQ_W-1:0] irq_mask_r;
  reg [15:0] count_r;
  reg [`RFCT_RX_CNT_W-1:0] rx_cnt_r;
  reg rx_done_r;

  wire [1:0] start_mode = ctrl_r[`RFCT_CTRL_START_HI:`RFCT_CTRL_START_LO];
  wire [1:0] clock_select = ctrl_r[`RFCT_CTRL_CLK_HI:`RFCT_CTRL_CLK_LO];
  wire stop_on_receive = ctrl_r[`RFCT_CTRL_STOPRX];
  wire auto_restart = ctrl_r[`RFCT_CTRL_AUTORST];
  wire lfo_mode = start_mode[1];

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_req = bus_req & wb_we_i & wb_sel_i[0];
  wire rd_req = bus_req & ~wb_we_i;
  wire [7:0] idx = wb_adr_i >> `RFCT_ADR_LSB;
  wire rd_stat = rd_req & (idx == `RFCT_IDX_IRQ_STAT);

  // ---------------------------------------------------------------
  // timer core
  // ---------------------------------------------------------------
  reg step;
  always @* begin
    case (clock_select)
      `RFCT_CLK_CARRIER: step = car_tick;
      `RFCT_CLK_DIV: step = div_tick;
      `RFCT_CLK_T0: step = t0_underflow_i;
      `RFCT_CLK_T1: step = t1_underflow_i;
      default: step = 1'b0;
    endcase
  end

  reg start_ev;
  reg stop_ev;
  always @* begin
    start_ev = 1'b0;
    stop_ev = 1'b0;
    case (start_mode)
      `RFCT_START_NONE: start_ev = 1'b0;
      `RFCT_START_TXEND: start_ev = tx_end_rise;
      `RFCT_START_LFO, `RFCT_START_LFO_UF: begin
        start_ev = lfo_rise & ~running_o;
        stop_ev = lfo_rise & running_o;
      end
      default: start_ev = 1'b0;
    endcase
  end

  // stop after four bits, not in trimming
  wire rx_stop = stop_on_receive & ~lfo_mode & rx_bit_rise & ~rx_done_r &
                 (rx_cnt_r == `RFCT_RX_STOP_BITS - 3'h1);
  wire at_zero = (count_r == `RFCT_CNT_RST);
  wire uf_ok = (start_mode != `RFCT_START_LFO);
  wire uf_now = running_o & step & at_zero & uf_ok & ~start_ev & ~rx_stop &
                ~stop_ev;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_cnt_r <= {`RFCT_RX_CNT_W{1'b0}};
      rx_done_r <= 1'b0;
    end else if (!sync2_r[1] && !rx_active_i) begin
      rx_cnt_r <= {`RFCT_RX_CNT_W{1'b0}};
      rx_done_r <= 1'b0;
    end else if (rx_bit_rise && !rx_done_r) begin
      rx_cnt_r <= rx_cnt_r + 3'h1;
      rx_done_r <= (rx_cnt_r == `RFCT_RX_STOP_BITS - 3'h1);
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_r <= `RFCT_CNT_RST;
      running_o <= 1'b0;
      underflow_o <= 1'b0;
    end else begin
      underflow_o <= uf_now;
      if (start_ev) begin
        count_r <= {rld_hi_r, rld_lo_r};
        running_o <= 1'b1;
      end else if (rx_stop || stop_ev) begin
        running_o <= 1'b0;
      end else if (running_o && step) begin
        if (at_zero) begin
          // mode 10 holds at zero, no wrap to all ones
          if (uf_ok) begin
            if (auto_restart) begin
              count_r <= {rld_hi_r, rld_lo_r};
            end else begin
              running_o <= 1'b0;
            end
          end
        end else begin
          count_r <= count_r - 16'h0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes and interrupt
  // ---------------------------------------------------------------
  // set wins over the read clear
  wire [`RFCT_IRQ_W-1:0] irq_set = {rx_stop, uf_now};
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_r <= `RFCT_CTRL_RST;
      rld_hi_r <= `RFCT_BYTE_RST;
      rld_lo_r <= `RFCT_BYTE_RST;
      irq_stat_r <= {`RFCT_IRQ_W{1'b0}};
      irq_mask_r <= {`RFCT_IRQ_W{1'b0}};
    end else begin
      if (wr_req) begin
        case (idx)
          `RFCT_IDX_CTRL: ctrl_r <= wb_dat_i[7:0] & `RFCT_CTRL_WMASK;
          `RFCT_IDX_RLD_HI: rld_hi_r <= wb_dat_i[7:0];
          `RFCT_IDX_RLD_LO: rld_lo_r <= wb_dat_i[7:0];
          `RFCT_IDX_IRQ_MASK: irq_mask_r <= wb_dat_i[`RFCT_IRQ_W-1:0];
          default: ctrl_r <= ctrl_r;
        endcase
      end
      irq_stat_r <= (rd_stat ? {`RFCT_IRQ_W{1'b0}} : irq_stat_r) | irq_set;
    end
  end
  assign irq_o = |(irq_stat_r & irq_mask_r);

  // ---------------------------------------------------------------
  // wishbone read and ack
  // ---------------------------------------------------------------
  reg [7:0] rd_byte;
  always @* begin
    case (idx)
      `RFCT_IDX_PREV_HI: rd_byte = prev_count_i[15:8];
      `RFCT_IDX_PREV_LO: rd_byte = prev_count_i[7:0];
      `RFCT_IDX_CTRL: rd_byte = ctrl_r;
      `RFCT_IDX_RLD_HI: rd_byte = rld_hi_r;
      `RFCT_IDX_RLD_LO: rd_byte = rld_lo_r;
      `RFCT_IDX_CNT_HI: rd_byte = count_r[15:8];
      `RFCT_IDX_CNT_LO: rd_byte = count_r[7:0];
      `RFCT_IDX_IRQ_STAT: rd_byte = {6'h00, irq_stat_r};
      `RFCT_IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_r};
      `RFCT_IDX_RUN: rd_byte = {7'h00, running_o};
      default: rd_byte = 8'h00;
    endcase
  end

  // one wait state; unmapped reads return zero, writes are dropped
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (rd_req) begin
        wb_dat_o <= {24'h000000, rd_byte};
      end
    end
  end
  assign wb_err_o = 1'b0;

endmodule

// File: verification/rfct_timer_assertions.sv
// Purpose: port checks for rfct_timer
// Assumes: one clock, synchronous reset
// Notes: control fields are internal, so checks stay on the bus and the running/underflow outputs
`timescale 1ns/1ps
module rfct_timer_chk (
  input logic clk_i,
  input logic sys_rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic [15:0] prev_count_i,
  input logic underflow_o,
  input logic running_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----
  // bus and timer outputs
  // ----
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(a);
    s_req ##0 (!wb_we_i && wb_adr_i == a);
  endsequence
  chk_ack_one_cycle: assert property (s_req |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_unmapped_zero: assert property (s_rd(8'hfc) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_ctrl_resv: assert property (s_rd(8'h78) |=>
    wb_dat_o[6] == 1'b0 && wb_dat_o[2] == 1'b0) else $error("reserved set");
  chk_prev_high: assert property (s_rd(8'h70) |=>
    {wb_dat_o[7:0], 8'h00} == ($past(prev_count_i) & 16'hff00))
    else $error("prev high wrong");
  chk_prev_low: assert property (s_rd(8'h74) |=>
    {8'h00, wb_dat_o[7:0]} == ($past(prev_count_i) & 16'h00ff))
    else $error("prev low wrong");
  chk_uf_running: assert property (underflow_o |-> $past(running_o))
    else $error("underflow while idle");
  chk_rst_quiet: assert property (disable iff (1'b0)
    sys_rst_i |=> !running_o && !underflow_o && !wb_ack_o)
    else $error("outputs active after reset");
endmodule
bind rfct_timer rfct_timer_chk u_chk (.clk_i, .sys_rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .prev_count_i,
  .underflow_o, .running_o);

// File: verification/tb.sv
// Purpose: register level tests of rfct_timer
// Assumes: 200 MHz clock, reset held 3 cycles
// Notes: event pins share one vector so one task pulses them
`timescale 1ns/1ps
module tb;
  logic clk_i = 0, sys_rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic rx_active_i = 0;
  logic [4:0] ev = 5'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [15:0] prev_count_i = 16'h0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wb_err_o, underflow_o, running_o, irq_o;
  int n_fail = 0, total_checks = 0;
  rfct_timer dut (.clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .tx_end_i(ev[0]), .rx_bit_i(ev[1]), .rx_active_i, .lfo_i(ev[2]),
    .t0_underflow_i(ev[3]), .t1_underflow_i(ev[4]), .prev_count_i,
    .underflow_o, .running_o, .irq_o);
  initial forever #2.5 clk_i = ~clk_i;
  // ----
  // tasks
  // ----
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task chk(input [15:0] g, input [15:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task bus(input w, input [7:0] a, input [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 40);
    if (n == 40) n_fail++;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task wr(input [7:0] a, d);
    bus(1'b1, a, d);
  endtask
  task rc(input [7:0] a, e);
    bus(1'b0, a, 8'h00);
    chk(wb_dat_o[7:0], e);
  endtask
  task cnt(input [15:0] e);
    rc(8'h84, e[15:8]);
    rc(8'h88, e[7:0]);
  endtask
  // async pins held 4 cycles, sibling underflows 1 cycle
  task pl(input int k, n, w);
    repeat (n) begin
      ev[k] <= 1'b1;
      tick(w);
      ev[k] <= 1'b0;
      tick(4);
    end
  endtask
  task rxp;
    rx_active_i <= 1'b1;
    pl(1, 4, 4);
    rx_active_i <= 1'b0;
    tick(2);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    tick(20000);
    n_fail++;
    conclude;
  end
  initial begin
    tick(3);
    sys_rst_i <= 0;
    for (logic [7:0] a = 8'h70; a <= 8'h88; a += 8'h04) rc(a, 8'h00);
    rc(8'hfc, 8'h00);
    wr(8'h78, 8'hff);
    rc(8'h78, 8'hbb);
    prev_count_i <= 16'hc35a;
    rc(8'h70, 8'hc3);
    rc(8'h74, 8'h5a);
    wr(8'h80, 8'h03);
    wr(8'h78, 8'h12);
    pl(0, 1, 4);
    cnt(16'h0003);
    wr(8'h80, 8'h05);
    rc(8'h80, 8'h05);
    cnt(16'h0003);
    pl(3, 3, 1);
    cnt(16'h0000);
    chk(running_o, 1'b1);
    pl(3, 2, 1);
    chk(running_o, 1'b0);
    cnt(16'h0000);
    chk(irq_o, 1'b0);
    wr(8'hc4, 8'h01);
    chk(irq_o, 1'b1);
    rc(8'hc0, 8'h01);
    chk(irq_o, 1'b0);
    wr(8'h78, 8'h1a);
    pl(0, 1, 4);
    cnt(16'h0005);
    pl(3, 6, 1);
    cnt(16'h0005);
    rc(8'hc0, 8'h01);
    wr(8'h78, 8'h1b);
    pl(4, 1, 1);
    pl(3, 1, 1);
    cnt(16'h0004);
    wr(8'h78, 8'h9b);
    rxp;
    chk(running_o, 1'b0);
    rc(8'hc0, 8'h02);
    cnt(16'h0004);
    wr(8'h78, 8'h0a);
    pl(0, 1, 4);
    chk(running_o, 1'b0);
    wr(8'h78, 8'hb2);
    pl(2, 1, 4);
    chk(running_o, 1'b1);
    rxp;
    chk(running_o, 1'b1);
    pl(2, 1, 4);
    chk(running_o, 1'b0);
    wr(8'h78, 8'ha2);
    pl(2, 1, 4);
    pl(3, 6, 1);
    cnt(16'h0000);
    chk(running_o, 1'b1);
    rc(8'hc0, 8'h00);
    pl(2, 1, 4);
    wr(8'h78, 8'h11);
    pl(0, 1, 4);
    tick(200);
    chk(running_o, 1'b1);
    wr(8'h78, 8'h10);
    tick(200);
    chk(running_o, 1'b0);
    rc(8'hc0, 8'h01);
    wr(8'h78, 8'h1a);
    pl(0, 1, 4);
    rxp;
    chk(running_o, 1'b1);
    chk(wb_err_o, 1'b0);
    conclude;
  end
endmodule
